// ===== include/gst_pkg.sv
// Constants and types of the gated sixteen-bit timer
// Behaviour
// - Source select 00 instruction clock, 01 system clock, 10 external or crystal.
// - Prescaler select 00 1:1, 01 1:2, 10 1:4, 11 1:8.
// - External code counts crystal when oscillator enable is 1, else the pin.
// - Crystal driver powered when either timer's oscillator enable is 1.
// - External input synchronised unless sync-bypass is 1; ignored internally.
// - Wide-access bit selects one 16-bit access or two byte accesses.
// - Count only while timer_on is 1; hold the count otherwise.
// - With gate enable, count only while gate active; ignored when off.
// - Gate polarity 1 counts while gate high, 0 while gate low.
// - Toggle mode passes gate through rising-edge toggle flop, else cleared.
// - Single-pulse mode bit hands gate control to the acquisition logic.
// - Acquisition status is 1 while armed, 0 when done or idle.
// - Clearing single-pulse mode clears the acquisition status.
// - Read-only gate level bit, independent of gate enable.
// - Gate source 00 pin, 01 sibling overflow, 10 period match.
// - Special event trigger clears the count.
// - Wide mode: low read copies high byte to buffer; high reads buffer.
// - Wide mode: high writes hit buffer; low write loads high from it.
// - Only low byte writes clear the prescaler.
// - External counts on rising edges, one falling edge needed after enable/write.
package gst_pkg;

	localparam int          ADDR_W         = 16;
	localparam logic [11:0] IDX_GATE_CTRL  = 12'hF9A;
	localparam logic [11:0] IDX_TIMER_CTRL = 12'hFCD;
	localparam logic [11:0] IDX_COUNT_LOW  = 12'hFCE;
	localparam logic [11:0] IDX_COUNT_HIGH = 12'hFCF;
	localparam logic [11:0] IDX_STATUS     = 12'hFD0;

	// Timer control fields
	localparam int TC_CS   = 6;
	localparam int TC_PS   = 4;
	localparam int TC_OSC  = 3;
	localparam int TC_SYNC = 2;
	localparam int TC_WIDE = 1;
	localparam int TC_ON   = 0;
	// Gate control and status fields
	localparam int GC_GE   = 7;
	localparam int GC_POL  = 6;
	localparam int GC_TM   = 5;
	localparam int GC_SPM  = 4;
	localparam int GC_GO   = 3;
	localparam int GC_VAL  = 2;
	localparam int GC_GSS  = 0;
	localparam int ST_OVF  = 0;

	localparam logic [7:0]  TCTL_RST   = 8'h00;
	localparam logic [7:0]  GCTL_RST   = 8'h00;
	localparam logic [7:0]  GCTL_WMASK = 8'hF3;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
	localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		GST_SRC_INSTR = 2'b00,
		GST_SRC_SYS   = 2'b01,
		GST_SRC_EXT   = 2'b10,
		GST_SRC_RSVD  = 2'b11
	} gst_src_t;

	typedef enum logic [1:0] {
		GST_GSRC_PIN   = 2'b00,
		GST_GSRC_OVF   = 2'b01,
		GST_GSRC_MATCH = 2'b10,
		GST_GSRC_RSVD  = 2'b11
	} gst_gsrc_t;

	typedef enum logic [1:0] {
		GST_SP_IDLE  = 2'b00,
		GST_SP_ARMED = 2'b01,
		GST_SP_RUN   = 2'b10
	} gst_sp_t;

	typedef enum logic [2:0] {
		GST_SEL_GATE = 3'b000,
		GST_SEL_TCTL = 3'b001,
		GST_SEL_LOW  = 3'b010,
		GST_SEL_HIGH = 3'b011,
		GST_SEL_STAT = 3'b100,
		GST_SEL_NONE = 3'b111
	} gst_sel_t;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : byte_addr

	function automatic gst_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		if (a == byte_addr(IDX_GATE_CTRL))
			return GST_SEL_GATE;
		if (a == byte_addr(IDX_TIMER_CTRL))
			return GST_SEL_TCTL;
		if (a == byte_addr(IDX_COUNT_LOW))
			return GST_SEL_LOW;
		if (a == byte_addr(IDX_COUNT_HIGH))
			return GST_SEL_HIGH;
		if (a == byte_addr(IDX_STATUS))
			return GST_SEL_STAT;
		return GST_SEL_NONE;
	endfunction : reg_sel

	function automatic logic [2:0] ps_last(input logic [1:0] sel);
		case (sel)
			2'h0:    return 3'h0;
			2'h1:    return 3'h1;
			2'h2:    return 3'h3;
			default: return 3'h7;
		endcase
	endfunction : ps_last

endpackage : gst_pkg

// ===== include/gst_if.sv
// Control and event signals between the timer core and its helpers
`timescale 1ns/1ps
interface gst_if;
	import gst_pkg::*;
	gst_src_t  src_sel;
	logic [1:0] ps_sel;
	logic      osc_en;
	logic      sync_bypass;
	logic      on;
	logic      gate_en;
	logic      gate_pol;
	logic      gate_tgl;
	logic      gate_spm;
	gst_gsrc_t gate_sel;
	logic      go_req;
	logic      pre_clr;
	logic      cnt_wr;
	logic      gate_open;
	logic      gate_val;
	logic      go;
	logic      tick;

	modport gate (
		input  gate_en, gate_pol, gate_tgl, gate_spm, gate_sel, go_req,
		output gate_open, gate_val, go
	);
	modport pre (
		input  src_sel, ps_sel, osc_en, sync_bypass, on, gate_open,
		input  pre_clr, cnt_wr,
		output tick
	);
endinterface : gst_if

// ===== logic/gst_gate.sv
// Gate path: source, polarity, toggle and single-pulse acquisition
`timescale 1ns/1ps
module gst_gate (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic gate_pin,
	input wire logic sibling_ovf,
	input wire logic period_match,
	gst_if.gate      bus
);
	import gst_pkg::*;

	logic    raw, pol, g1;
	logic    pol_q, tff, g1_q, val;
	logic    next_pol_q, next_tff, next_g1_q, next_val;
	gst_sp_t sp, next_sp;

	always_comb begin
		case (bus.gate_sel)
			GST_GSRC_PIN:   raw = gate_pin;
			GST_GSRC_OVF:   raw = sibling_ovf;
			GST_GSRC_MATCH: raw = period_match;
			default:        raw = 1'b0;
		endcase
		pol = bus.gate_pol ? raw : ~raw;
		next_pol_q = pol;
		next_tff = bus.gate_tgl ? (tff ^ (pol & ~pol_q)) : 1'b0;
		g1 = bus.gate_tgl ? tff : pol;
		next_g1_q = g1;
		next_sp = sp;
		if (!bus.gate_spm) begin
			next_sp = GST_SP_IDLE;
		end else begin
			case (sp)
				GST_SP_IDLE:  if (bus.go_req) next_sp = GST_SP_ARMED;
				GST_SP_ARMED: if (g1 & ~g1_q) next_sp = GST_SP_RUN;
				GST_SP_RUN:   if (~g1 & g1_q) next_sp = GST_SP_IDLE;
				default:      next_sp = GST_SP_IDLE;
			endcase
		end
		// Single pulse passes only the one captured gate pulse
		next_val = bus.gate_spm ? (sp == GST_SP_RUN && g1) : g1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pol_q <= 1'b0;
			tff   <= 1'b0;
			g1_q  <= 1'b0;
			val   <= 1'b0;
			sp    <= GST_SP_IDLE;
		end else begin
			pol_q <= next_pol_q;
			tff   <= next_tff;
			g1_q  <= next_g1_q;
			val   <= next_val;
			sp    <= next_sp;
		end
	end

	assign bus.gate_val  = val;
	assign bus.go        = (sp != GST_SP_IDLE);
	assign bus.gate_open = !bus.gate_en || val;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_spm_off_idle: assert property (
		!bus.gate_spm |=> !bus.go)
		else $error("acquisition status stayed set");
	a_tgl_off_clear: assert property (
		!bus.gate_tgl |=> !tff)
		else $error("toggle flop not cleared");
	a_arm_sets_go: assert property (
		bus.gate_spm && bus.go_req && sp == GST_SP_IDLE |=> bus.go)
		else $error("acquisition not armed");
	a_pulse_done: assert property (
		bus.gate_spm && sp == GST_SP_RUN && !g1 && g1_q |=> !bus.go)
		else $error("acquisition not completed");
endmodule : gst_gate

// ===== logic/gst_prescale.sv
// Count source selection, external edge logic and prescaler
`timescale 1ns/1ps
module gst_prescale (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ext_count_pin,
	input wire logic xtal_osc,
	gst_if.pre       bus
);
	import gst_pkg::*;

	logic       s1, s2, ext_q, armed, tick;
	logic       next_s1, next_s2, next_ext_q, next_armed, next_tick;
	logic [1:0] div, next_div;
	logic [2:0] pre, next_pre;
	logic       ext_raw, ext_now, rise, fall, src_tick, en;

	always_comb begin
		ext_raw = bus.osc_en ? xtal_osc : ext_count_pin;
		ext_now = bus.sync_bypass ? ext_raw : s2;
		rise = ext_now & ~ext_q;
		fall = ~ext_now & ext_q;
		next_s1 = ext_raw;
		next_s2 = s1;
		next_ext_q = ext_now;
		next_div = div + 2'h1;
		// Rising edge counts only after a falling edge was seen
		if (!bus.on || bus.cnt_wr)
			next_armed = 1'b0;
		else if (fall)
			next_armed = 1'b1;
		else
			next_armed = armed;
		case (bus.src_sel)
			GST_SRC_INSTR: src_tick = (div == INSTR_DIV_LAST);
			GST_SRC_SYS:   src_tick = 1'b1;
			GST_SRC_EXT:   src_tick = rise & armed;
			default:       src_tick = 1'b0;
		endcase
		en = bus.on && bus.gate_open && src_tick;
		next_pre = pre;
		next_tick = 1'b0;
		if (bus.pre_clr) begin
			next_pre = 3'h0;
		end else if (en) begin
			// A ratio lowered on the fly must not wrap the prescaler
			if (pre >= ps_last(bus.ps_sel)) begin
				next_pre = 3'h0;
				next_tick = 1'b1;
			end else begin
				next_pre = pre + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			ext_q <= 1'b0;
			armed <= 1'b0;
			tick  <= 1'b0;
			div   <= 2'h0;
			pre   <= 3'h0;
		end else begin
			s1    <= next_s1;
			s2    <= next_s2;
			ext_q <= next_ext_q;
			armed <= next_armed;
			tick  <= next_tick;
			div   <= next_div;
			pre   <= next_pre;
		end
	end

	assign bus.tick = tick;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_pre_clear: assert property (
		bus.pre_clr |=> pre == 3'h0)
		else $error("prescaler not cleared");
	a_off_no_tick: assert property (
		!bus.on |=> !bus.tick)
		else $error("count tick while off");
	a_ext_need_fall: assert property (
		bus.src_sel == GST_SRC_EXT && !armed |=> !bus.tick)
		else $error("edge counted before falling edge");
	a_sys_rate: assert property (
		bus.src_sel == GST_SRC_SYS && bus.ps_sel == 2'h0 && bus.on &&
		bus.gate_open && !bus.pre_clr |=> bus.tick)
		else $error("system clock tick missing");
endmodule : gst_prescale

// ===== logic/gst_timer.sv
// Gated sixteen-bit timer with its register slave on AXI4-Lite
`timescale 1ns/1ps
module gst_timer (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic [gst_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [gst_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     ext_count_pin,
	input  wire logic                     xtal_osc,
	input  wire logic                     gate_pin,
	input  wire logic                     sibling_ovf,
	input  wire logic                     period_match,
	input  wire logic                     special_event,
	input  wire logic                     sibling_xtal_driver_en,
	output logic                          xtal_driver_pwr,
	output logic                          ovf_flag
);
	import gst_pkg::*;

	gst_if bus ();

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [7:0]        tctl, gctl, hbuf, wbyte;
	logic [15:0]       count;
	logic              ovf, pwr, go_pend, wlane;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	logic [ADDR_W-1:0] waddr;

	logic [7:0]        next_tctl, next_gctl, next_hbuf, next_wbyte;
	logic [15:0]       next_count;
	logic              next_ovf, next_pwr, next_go_pend, next_wlane;
	logic              next_awready, next_wready, next_bvalid;
	logic              next_arready, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [31:0]       next_rdata;
	logic [ADDR_W-1:0] next_waddr;

	gst_sel_t          wsel, rsel;
	logic              do_wr, wen, wr_low, wr_high, ar_hs, rd_low, wide;
	logic [7:0]        gread;
	logic [7:0]        count_hi;
	logic              pwr_req;

	assign wide     = tctl[TC_WIDE];
	assign count_hi = count[15:8];
	assign pwr_req  = tctl[TC_OSC] | sibling_xtal_driver_en;

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	assign bus.src_sel     = gst_src_t'(tctl[TC_CS +: 2]);
	assign bus.ps_sel      = tctl[TC_PS +: 2];
	assign bus.osc_en      = tctl[TC_OSC];
	assign bus.sync_bypass = tctl[TC_SYNC];
	assign bus.on          = tctl[TC_ON];
	assign bus.gate_en     = gctl[GC_GE];
	assign bus.gate_pol    = gctl[GC_POL];
	assign bus.gate_tgl    = gctl[GC_TM];
	assign bus.gate_spm    = gctl[GC_SPM];
	assign bus.gate_sel    = gst_gsrc_t'(gctl[GC_GSS +: 2]);
	assign bus.go_req      = go_pend;
	assign bus.pre_clr     = wr_low;
	assign bus.cnt_wr      = wr_low | wr_high;

	gst_gate u_gate (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.gate_pin     (gate_pin),
		.sibling_ovf  (sibling_ovf),
		.period_match (period_match),
		.bus          (bus.gate)
	);

	gst_prescale u_pre (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.ext_count_pin (ext_count_pin),
		.xtal_osc      (xtal_osc),
		.bus           (bus.pre)
	);

	// -----------------------------------------------------------------
	// Write channel
	// -----------------------------------------------------------------
	// Address and data are taken in either order; write waits for both
	assign do_wr = !awready && !wready && !bvalid;

	always_comb begin
		next_awready = awready;
		next_wready  = wready;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_waddr   = waddr;
		next_wbyte   = wbyte;
		next_wlane   = wlane;
		if (s_axi_awvalid && awready) begin
			next_awready = 1'b0;
			next_waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready) begin
			next_wready = 1'b0;
			next_wbyte  = s_axi_wdata[7:0];
			next_wlane  = s_axi_wstrb[0];
		end
		if (do_wr) begin
			next_bvalid = 1'b1;
			next_bresp  = (wsel == GST_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Registers and counter
	// -----------------------------------------------------------------
	always_comb begin
		wsel    = reg_sel(waddr);
		wen     = do_wr && wlane;
		wr_low  = wen && wsel == GST_SEL_LOW;
		wr_high = wen && wsel == GST_SEL_HIGH;
		ar_hs   = s_axi_arvalid && arready;
		rsel    = reg_sel(s_axi_araddr);
		rd_low  = ar_hs && rsel == GST_SEL_LOW && wide;
		next_tctl = tctl;
		if (wen && wsel == GST_SEL_TCTL)
			next_tctl = wbyte;
		next_gctl = gctl;
		if (wen && wsel == GST_SEL_GATE)
			next_gctl = wbyte & GCTL_WMASK;
		// Arm one cycle late so a joint mode-and-go write arms
		next_go_pend = wen && wsel == GST_SEL_GATE &&
			wbyte[GC_GO] && wbyte[GC_SPM];
		next_hbuf = hbuf;
		if (rd_low)
			next_hbuf = count_hi;
		if (wr_high && wide)
			next_hbuf = wbyte;
		next_count = count;
		if (bus.tick)
			next_count = count + 16'h0001;
		if (wr_low) begin
			next_count[7:0] = wbyte;
			if (wide)
				next_count[15:8] = hbuf;
		end
		if (wr_high && !wide)
			next_count[15:8] = wbyte;
		if (special_event)
			next_count = COUNT_RST;
		// Set beats clear on the same edge
		next_ovf = ovf;
		if (wen && wsel == GST_SEL_STAT && wbyte[ST_OVF])
			next_ovf = 1'b0;
		if (bus.tick && count == COUNT_MAX)
			next_ovf = 1'b1;
		next_pwr = pwr_req;
	end

	// -----------------------------------------------------------------
	// Read channel
	// -----------------------------------------------------------------
	always_comb begin
		gread         = gctl;
		gread[GC_GO]  = bus.go;
		gread[GC_VAL] = bus.gate_val;
		next_arready  = arready;
		next_rvalid   = rvalid;
		next_rdata    = rdata;
		next_rresp    = rresp;
		if (ar_hs) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = RESP_OKAY;
			next_rdata   = 32'h0000_0000;
			case (rsel)
				GST_SEL_GATE: next_rdata[7:0] = gread;
				GST_SEL_TCTL: next_rdata[7:0] = tctl;
				GST_SEL_LOW:  next_rdata[7:0] = count[7:0];
				GST_SEL_HIGH: next_rdata[7:0] = wide ? hbuf : count_hi;
				GST_SEL_STAT: next_rdata[ST_OVF] = ovf;
				default:      next_rresp = RESP_SLVERR;
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tctl    <= TCTL_RST;
			gctl    <= GCTL_RST;
			hbuf    <= 8'h00;
			count   <= COUNT_RST;
			ovf     <= 1'b0;
			pwr     <= 1'b0;
			go_pend <= 1'b0;
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			waddr   <= '0;
			wbyte   <= 8'h00;
			wlane   <= 1'b0;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else begin
			tctl    <= next_tctl;
			gctl    <= next_gctl;
			hbuf    <= next_hbuf;
			count   <= next_count;
			ovf     <= next_ovf;
			pwr     <= next_pwr;
			go_pend <= next_go_pend;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			waddr   <= next_waddr;
			wbyte   <= next_wbyte;
			wlane   <= next_wlane;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	assign s_axi_awready   = awready;
	assign s_axi_wready    = wready;
	assign s_axi_bvalid    = bvalid;
	assign s_axi_bresp     = bresp;
	assign s_axi_arready   = arready;
	assign s_axi_rvalid    = rvalid;
	assign s_axi_rdata     = rdata;
	assign s_axi_rresp     = rresp;
	assign xtal_driver_pwr = pwr;
	assign ovf_flag        = ovf;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_buf_wr;
		wr_high && wide;
	endsequence
	sequence s_off_quiet;
		!bus.on ##1 (!bus.on && !special_event && !bus.cnt_wr);
	endsequence

	a_sev_clear: assert property (
		special_event |=> count == COUNT_RST)
		else $error("special event did not clear count");
	a_roll_flag: assert property (
		bus.tick && count == COUNT_MAX && !special_event && !bus.cnt_wr
		|=> ovf && count == COUNT_RST)
		else $error("rollover did not set flag");
	a_low_rd_copy: assert property (
		rd_low && !(wr_high && wide) |=> hbuf == $past(count_hi))
		else $error("high byte not buffered on low read");
	a_high_buf_wr: assert property (
		s_buf_wr |=> hbuf == $past(wbyte))
		else $error("high write missed buffer");
	a_low_wr_load: assert property (
		wr_low && wide && !special_event |=> count_hi == $past(hbuf))
		else $error("high byte not loaded from buffer");
	a_off_hold: assert property (
		s_off_quiet |=> $stable(count))
		else $error("count moved while off");
	a_xtal_pwr: assert property (
		1'b1 |=> xtal_driver_pwr == $past(pwr_req))
		else $error("crystal power wrong");
endmodule : gst_timer

// ===== dv/tb.sv
// Self-checking testbench of the gated sixteen-bit timer
`timescale 1ns/1ps
module tb;
	import gst_pkg::*;
	localparam logic [15:0] A_G = {2'h0, IDX_GATE_CTRL, 2'h0};
	localparam logic [15:0] A_T = {2'h0, IDX_TIMER_CTRL, 2'h0};
	localparam logic [15:0] A_L = {2'h0, IDX_COUNT_LOW, 2'h0};
	localparam logic [15:0] A_H = {2'h0, IDX_COUNT_HIGH, 2'h0};
	localparam logic [15:0] A_S = {2'h0, IDX_STATUS, 2'h0};
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk, sys_rst;
	logic [15:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	logic        ext_pin, xtal, gpin, s_ovf, pmatch, sev, s_osc, pwr, ovf;
	int          mismatches, n_tests;
	// ----------------------------------------
	// Design
	// ----------------------------------------
	gst_timer DUT (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_count_pin(ext_pin), .xtal_osc(xtal), .gate_pin(gpin),
		.sibling_ovf(s_ovf), .period_match(pmatch), .special_event(sev),
		.sibling_xtal_driver_en(s_osc), .xtal_driver_pwr(pwr),
		.ovf_flag(ovf)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic tmo;
		mismatches++;
		finish_test();
	endtask : tmo
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
		n_tests++;
		if ($isunknown(g) || g < lo || g > hi) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h..%h", $time, g, lo, hi);
		end
	endtask : chk_rng
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		int i;
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		rsp = bresp;
		if (i == 50)
			tmo();
	endtask : wr
	task automatic rd_reg(input logic [15:0] a);
		int i;
		araddr  <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		rd  = rdata;
		rsp = rresp;
		if (i == 50)
			tmo();
	endtask : rd_reg
	// Clears count, runs n cycles or n source pulses, stops, reads low byte
	task automatic run(input logic [7:0] tc, input int n, input int sel);
		wr(A_H, 8'h00);
		wr(A_L, 8'h00);
		wr(A_T, tc | 8'h01);
		if (sel == 0)
			cyc(n);
		else
			repeat (n) begin
				ext_pin <= (sel == 1);
				xtal    <= (sel == 2);
				cyc(4);
				ext_pin <= 1'b0;
				xtal    <= 1'b0;
				cyc(4);
			end
		wr(A_T, tc);
		rd_reg(A_L);
	endtask : run
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_reg(A_T);
		chk(rd, 32'h0);
		rd_reg(16'h0004);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(16'h0004, 8'hFF);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		$display("test reset done");
	endtask : t_reset
	task automatic t_count;
		int k;
		int d;
		for (k = 0; k < 5; k++) begin
			d = (k < 4) ? (1 << k) : 4;
			run((k < 4) ? {2'b01, k[1:0], 4'h0} : 8'h00, 64, 0);
			chk_rng(rd, 64 / d - 2, 72 / d + 2);
		end
		cyc(40);
		rd_reg(A_L);
		chk_rng(rd, 14, 20);
		$display("test count done");
	endtask : t_count
	task automatic t_ext;
		int k;
		logic [7:0] tcs [3] = '{8'h80, 8'h84, 8'h88};
		for (k = 0; k < 3; k++) begin
			// First rise after the count write lacks a falling edge
			run(tcs[k], 5, (k == 2) ? 2 : 1);
			chk(rd, 32'h4);
		end
		// Bypass counts a rise two cycles sooner than the synchroniser
		for (k = 0; k < 2; k++) begin
			wr(A_L, 8'h00);
			wr(A_T, tcs[k] | 8'h01);
			ext_pin <= 1'b1;
			cyc(4);
			ext_pin <= 1'b0;
			cyc(4);
			ext_pin <= 1'b1;
			cyc(2);
			rd_reg(A_L);
			ext_pin <= 1'b0;
			wr(A_T, tcs[k]);
			chk(rd, {31'h0, k[0]});
		end
		$display("test ext done");
	endtask : t_ext
	task automatic t_wide;
		wr(A_T, 8'h02);
		wr(A_H, 8'h12);
		wr(A_L, 8'h34);
		wr(A_H, 8'h56);
		wr(A_T, 8'h00);
		rd_reg(A_H);
		chk(rd, 32'h12);
		rd_reg(A_L);
		chk(rd, 32'h34);
		wr(A_H, 8'h77);
		wr(A_T, 8'h02);
		rd_reg(A_H);
		chk(rd, 32'h56);
		rd_reg(A_L);
		rd_reg(A_H);
		chk(rd, 32'h77);
		$display("test wide done");
	endtask : t_wide
	task automatic t_misc;
		int k;
		for (k = 0; k < 4; k++) begin
			s_osc <= k[1];
			wr(A_T, {4'h0, k[0], 3'h0});
			cyc(2);
			chk({31'h0, pwr}, {31'h0, k[0] | k[1]});
		end
		wr(A_T, 8'h01);
		cyc(40);
		sev <= 1'b1;
		cyc(1);
		sev <= 1'b0;
		wr(A_T, 8'h00);
		rd_reg(A_L);
		chk_rng(rd, 0, 5);
		wr(A_H, 8'hFF);
		wr(A_L, 8'hF0);
		chk({31'h0, ovf}, 32'h0);
		wr(A_T, 8'h41);
		cyc(24);
		wr(A_T, 8'h40);
		chk({31'h0, ovf}, 32'h1);
		rd_reg(A_S);
		chk(rd, 32'h1);
		wr(A_S, 8'h01);
		cyc(1);
		chk({31'h0, ovf}, 32'h0);
		$display("test misc done");
	endtask : t_misc
	task automatic t_gate;
		int k;
		logic [7:0] gcs [8] = '{8'hC0, 8'hC0, 8'h80, 8'h80,
			8'h00, 8'hC1, 8'hC2, 8'hC1};
		logic [7:0] on = 8'h7A;
		for (k = 0; k < 8; k++) begin
			gpin   <= k[0] ^ k[1] ^ k[2] ^ (k == 7);
			s_ovf  <= (k == 5);
			pmatch <= (k == 6);
			wr(A_G, gcs[k]);
			run(8'h40, 32, 0);
			chk_rng(rd, on[k] ? 30 : 0, on[k] ? 40 : 0);
		end
		for (k = 0; k < 2; k++) begin
			gpin <= k[0];
			wr(A_G, 8'h40);
			rd_reg(A_G);
			chk(rd & 32'h4, {29'h0, k[0], 2'h0});
		end
		$display("test gate done");
	endtask : t_gate
	task automatic t_pulse;
		int k;
		gpin <= 1'b0;
		wr(A_G, 8'hD8);
		cyc(3);
		rd_reg(A_G);
		chk(rd & 32'h8, 32'h8);
		gpin <= 1'b1;
		cyc(4);
		gpin <= 1'b0;
		cyc(4);
		rd_reg(A_G);
		chk(rd & 32'h8, 32'h0);
		wr(A_G, 8'hD8);
		cyc(3);
		wr(A_G, 8'hC0);
		cyc(2);
		rd_reg(A_G);
		chk(rd & 32'h8, 32'h0);
		// Only the first gate pulse after arming may be counted
		wr(A_L, 8'h00);
		wr(A_G, 8'hD8);
		wr(A_T, 8'h41);
		repeat (2) begin
			gpin <= 1'b1;
			cyc(8);
			gpin <= 1'b0;
			cyc(4);
		end
		wr(A_T, 8'h40);
		rd_reg(A_L);
		chk_rng(rd, 5, 9);
		wr(A_G, 8'hE0);
		for (k = 0; k < 2; k++) begin
			gpin <= 1'b1;
			cyc(3);
			gpin <= 1'b0;
			cyc(3);
			run(8'h40, 32, 0);
			chk_rng(rd, k ? 0 : 30, k ? 0 : 40);
		end
		$display("test pulse done");
	endtask : t_pulse
	// ----------------------------------------
	// Main
	// ----------------------------------------
	initial begin
		{awvalid, wvalid, arvalid, ext_pin, xtal} = '0;
		{gpin, s_ovf, pmatch, sev, s_osc} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		// Answers are always accepted, so strobes and readies stay high
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		sys_rst = 1'b1;
		mismatches = 0;
		n_tests = 0;
		cyc(5);
		sys_rst <= 1'b0;
		cyc(1);
		t_reset();
		t_count();
		t_ext();
		t_wide();
		t_misc();
		t_gate();
		t_pulse();
		finish_test();
	end
endmodule : tb
